/* File: rtl/urd_pkg.sv */
// Purpose: Shared constants and types for the serial port rate divider and status block
// Assumes: Byte-wide register file, 12-bit register addresses
// Notes:   Offsets, fields and counts used by the logic are named here, except the frame status bits and synchroniser depth
package urd_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_HOLDING = 12'hf40;
  localparam logic [11:0] ADDR_LINE_STATUS = 12'hf41;
  localparam logic [11:0] ADDR_LINE_CONTROL = 12'hf42;
  localparam logic [11:0] ADDR_AUX_CONTROL = 12'hf43;
  localparam logic [11:0] ADDR_FRAME_STATUS = 12'hf44;
  localparam logic [11:0] ADDR_DIV_HIGH = 12'hf46;
  localparam logic [11:0] ADDR_DIV_LOW = 12'hf47;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] LINE_CONTROL_RST = 8'h00;
  localparam logic [7:0] AUX_CONTROL_RST = 8'h00;
  localparam logic [7:0] DIV_HIGH_RST = 8'hff;
  localparam logic [7:0] DIV_LOW_RST = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] OS_MID = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [2:0] DATA_LAST = 3'h7;
  localparam logic [15:0] DIV_ONE = 16'h0001;
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 8;

  // ---------------------------------------------------------------
  // Register layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic transmitter_on;
    logic receiver_on;
    logic flow_control_gate;
    logic parity_on;
    logic parity_odd;
    logic force_break;
    logic two_stop;
    logic loopback_on;
  } urd_line_control_s;

  typedef struct packed {
    logic mp_mode_hi;
    logic mp_on;
    logic mp_mode_lo;
    logic mp_send_bit;
    logic de_polarity;
    logic divider_timer_ctl;
    logic rx_irq_off;
    logic ir_on;
  } urd_aux_control_s;

  typedef struct packed {
    logic rx_byte_waiting;
    logic parity_fault;
    logic overrun;
    logic framing_fault;
    logic line_break_seen;
    logic tx_holding_empty;
    logic shifter_idle;
    logic cts_level;
  } urd_line_status_s;

  typedef enum logic [2:0] {
    SER_IDLE,
    SER_START,
    SER_DATA,
    SER_NINTH,
    SER_STOP,
    SER_STOP2
  } urd_ser_state_e;

endpackage : urd_pkg

/* File: rtl/urd_top.sv */
// Purpose: Rate divider, holding registers, line and frame status of a serial port
// Assumes: Register file strobes are one-cycle pulses on i_mclk; pins are asynchronous
// Notes:   Transmit bytes pass an 8-word FIFO; read data appears one cycle after i_rd
`timescale 1ns/100ps

// ---------------------------------------------------------------
// Transmit FIFO
// ---------------------------------------------------------------
module urd_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_mclk) begin
    if (i_ce && push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : urd_fifo

// Functional notes
// - Divisor is high byte over low byte, sixteen bits.
// - Bit rate is system clock over sixteen times divisor.
// - With port disabled, divider runs as 16-bit timer raising interrupts.
// - Timer interrupt comes every divisor count of system clocks.
// - Bytes written to transmit holding are shifted out on the pin.
// - Receive holding shares the transmit address; reads return last byte.
// - Line status bits: waiting, parity, overrun, framing, break, empty, idle, cts.
// - Byte-waiting flag sets on received byte, clears on receive read.
// - Parity fault sets on bad parity, clears on receive read.
// - Overrun sets on unread byte; read clears only when waiting flag zero.
// - Framing fault sets on missing stop bit, clears on receive read.
// - Break flag sets when data, ninth and stop bits are zero.
// - Holding-empty sets when room exists, clears on any transmit write.
// - Shifter-idle high only when shifter empty and character fully sent.
// - Line status bit 0 returns present clear-to-send level.
// - First-of-frame set on first data byte of frame, cleared by receive read.
// - Frame status reports last ninth bit, zeroed by receive read.
// - Line control resets to zero with the listed eight fields.
// - Receiver off plus timer bit: interrupt as the count reaches one, reads return running count.
// - On overrun the held byte is kept, new character discarded.
module urd_top (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [11:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_serial_in_pin,
  input wire logic i_cts_n,
  output logic o_serial_out_pin,
  output logic o_timer_irq,
  output logic o_tx_ready
);
  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  urd_pkg::urd_line_control_s ctl_reg;
  urd_pkg::urd_aux_control_s aux_reg;
  logic [7:0] div_hi_reg;
  logic [7:0] div_lo_reg;
  logic [15:0] divisor;
  logic [15:0] cnt_reg;
  logic tick_reg;
  logic [7:0] rx_holding_reg;
  logic rda_reg;
  logic pe_reg;
  logic oe_reg;
  logic fe_reg;
  logic brk_reg;
  logic tx_holding_empty_reg;
  logic first_reg;
  logic ninth_reg;
  logic prev_addr_reg;
  logic wr_hold;
  logic rd_hold;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic tx_take;

  assign divisor = {div_hi_reg, div_lo_reg};
  assign wr_hold = i_wr && (i_addr == urd_pkg::ADDR_HOLDING);
  assign rd_hold = i_rd && (i_addr == urd_pkg::ADDR_HOLDING);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] rx_sync_reg;
  logic [2:0] cts_sync_reg;
  logic rx_level_reg;
  logic cts_n_level_reg;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rx_sync_reg <= 3'h7;
      cts_sync_reg <= 3'h7;
      rx_level_reg <= 1'b1;
      cts_n_level_reg <= 1'b1;
    end else if (i_ce) begin
      rx_sync_reg <= {rx_sync_reg[1:0], i_serial_in_pin};
      cts_sync_reg <= {cts_sync_reg[1:0], i_cts_n};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_level_reg <= rx_sync_reg[2];
      end
      if (cts_sync_reg[1] == cts_sync_reg[2]) begin
        cts_n_level_reg <= cts_sync_reg[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Writes are taken whenever they come; keeping them to a disabled port is
  // left to software, so a mid-character change takes effect at once.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ctl_reg <= urd_pkg::urd_line_control_s'(urd_pkg::LINE_CONTROL_RST);
      aux_reg <= urd_pkg::urd_aux_control_s'(urd_pkg::AUX_CONTROL_RST);
      div_hi_reg <= urd_pkg::DIV_HIGH_RST;
      div_lo_reg <= urd_pkg::DIV_LOW_RST;
    end else if (i_ce && i_wr) begin
      case (i_addr)
        urd_pkg::ADDR_LINE_CONTROL: ctl_reg <= urd_pkg::urd_line_control_s'(i_wdata);
        urd_pkg::ADDR_AUX_CONTROL: aux_reg <= urd_pkg::urd_aux_control_s'(i_wdata);
        urd_pkg::ADDR_DIV_HIGH: div_hi_reg <= i_wdata;
        urd_pkg::ADDR_DIV_LOW: div_lo_reg <= i_wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Rate divider and timer
  // ---------------------------------------------------------------
  // Counts system clocks; each reload is one sixteenth of a bit, so the bit
  // rate is the clock over sixteen times the divisor. A zero divisor acts as one.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cnt_reg <= {urd_pkg::DIV_HIGH_RST, urd_pkg::DIV_LOW_RST};
      tick_reg <= 1'b0;
    end else if (i_ce) begin
      if (i_wr && (i_addr == urd_pkg::ADDR_DIV_HIGH || i_addr == urd_pkg::ADDR_DIV_LOW)) begin
        cnt_reg <= (i_addr == urd_pkg::ADDR_DIV_LOW) ? {div_hi_reg, i_wdata}
                   : {i_wdata, div_lo_reg};
        tick_reg <= 1'b0;
      end else if (cnt_reg <= urd_pkg::DIV_ONE) begin
        cnt_reg <= divisor;
        tick_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - urd_pkg::DIV_ONE;
        tick_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_timer_irq <= 1'b0;
    end else if (i_ce) begin
      o_timer_irq <= tick_reg && !ctl_reg.receiver_on && aux_reg.divider_timer_ctl;
    end
  end

  // ---------------------------------------------------------------
  // Transmit path
  // ---------------------------------------------------------------
  urd_fifo #(
    .WIDTH(urd_pkg::FIFO_WIDTH),
    .DEPTH(urd_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_in_valid(wr_hold),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_wdata),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(tx_take),
    .o_out_data(fifo_out_data)
  );

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tx_holding_empty_reg <= 1'b1;
      o_tx_ready <= 1'b1;
    end else if (i_ce) begin
      tx_holding_empty_reg <= wr_hold ? 1'b0 : fifo_in_ready;
      o_tx_ready <= wr_hold ? 1'b0 : fifo_in_ready;
    end
  end

  urd_pkg::urd_ser_state_e tx_state_reg;
  logic [3:0] tx_os_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic tx_ninth_reg;
  logic tx_line_reg;
  logic tx_allowed;

  assign tx_allowed = ctl_reg.transmitter_on && (!ctl_reg.flow_control_gate || !cts_n_level_reg);
  assign tx_take = (tx_state_reg == urd_pkg::SER_IDLE) && tx_allowed && tick_reg;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tx_state_reg <= urd_pkg::SER_IDLE;
      tx_os_reg <= '0;
      tx_bit_reg <= '0;
      tx_shift_reg <= urd_pkg::BYTE_ZERO;
      tx_ninth_reg <= 1'b0;
      tx_line_reg <= 1'b1;
    end else if (i_ce && tick_reg) begin
      tx_os_reg <= tx_os_reg + 1'b1;
      case (tx_state_reg)
        urd_pkg::SER_IDLE: begin
          tx_line_reg <= 1'b1;
          if (tx_take && fifo_out_valid) begin
            tx_shift_reg <= fifo_out_data;
            tx_ninth_reg <= aux_reg.mp_on ? aux_reg.mp_send_bit
                            : (^fifo_out_data) ^ ctl_reg.parity_odd;
            tx_os_reg <= '0;
            tx_line_reg <= 1'b0;
            tx_state_reg <= urd_pkg::SER_START;
          end
        end
        urd_pkg::SER_START: begin
          if (tx_os_reg == urd_pkg::OS_LAST) begin
            tx_line_reg <= tx_shift_reg[0];
            tx_bit_reg <= '0;
            tx_state_reg <= urd_pkg::SER_DATA;
          end
        end
        urd_pkg::SER_DATA: begin
          if (tx_os_reg == urd_pkg::OS_LAST) begin
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bit_reg <= tx_bit_reg + 1'b1;
            if (tx_bit_reg != urd_pkg::DATA_LAST) begin
              tx_line_reg <= tx_shift_reg[1];
            end else if (ctl_reg.parity_on || aux_reg.mp_on) begin
              tx_line_reg <= tx_ninth_reg;
              tx_state_reg <= urd_pkg::SER_NINTH;
            end else begin
              tx_line_reg <= 1'b1;
              tx_state_reg <= urd_pkg::SER_STOP;
            end
          end
        end
        urd_pkg::SER_NINTH: begin
          if (tx_os_reg == urd_pkg::OS_LAST) begin
            tx_line_reg <= 1'b1;
            tx_state_reg <= urd_pkg::SER_STOP;
          end
        end
        urd_pkg::SER_STOP: begin
          if (tx_os_reg == urd_pkg::OS_LAST) begin
            tx_state_reg <= ctl_reg.two_stop ? urd_pkg::SER_STOP2 : urd_pkg::SER_IDLE;
          end
        end
        urd_pkg::SER_STOP2: begin
          if (tx_os_reg == urd_pkg::OS_LAST) begin
            tx_state_reg <= urd_pkg::SER_IDLE;
          end
        end
        default: tx_state_reg <= urd_pkg::SER_IDLE;
      endcase
    end
  end

  // Break forces the line low at once, cutting any character in flight
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_serial_out_pin <= 1'b1;
    end else if (i_ce) begin
      o_serial_out_pin <= tx_line_reg && !ctl_reg.force_break;
    end
  end

  // ---------------------------------------------------------------
  // Receive path
  // ---------------------------------------------------------------
  urd_pkg::urd_ser_state_e rx_state_reg;
  logic [3:0] rx_os_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic rx_ninth_reg;
  logic rx_in;
  logic rx_done;
  logic rx_stop_ok;
  logic rx_mid;

  assign rx_in = ctl_reg.loopback_on ? tx_line_reg : rx_level_reg;
  assign rx_mid = tick_reg && (rx_os_reg == urd_pkg::OS_MID);
  assign rx_done = i_ce && rx_mid && (rx_state_reg == urd_pkg::SER_STOP);
  assign rx_stop_ok = rx_in;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rx_state_reg <= urd_pkg::SER_IDLE;
      rx_os_reg <= '0;
      rx_bit_reg <= '0;
      rx_shift_reg <= urd_pkg::BYTE_ZERO;
      rx_ninth_reg <= 1'b0;
    end else if (i_ce && tick_reg) begin
      rx_os_reg <= rx_os_reg + 1'b1;
      case (rx_state_reg)
        urd_pkg::SER_IDLE: begin
          rx_os_reg <= '0;
          rx_ninth_reg <= 1'b0;
          if (ctl_reg.receiver_on && !rx_in) begin
            rx_os_reg <= 4'h1;
            rx_state_reg <= urd_pkg::SER_START;
          end
        end
        urd_pkg::SER_START: begin
          if (rx_mid) begin
            rx_bit_reg <= '0;
            rx_state_reg <= rx_in ? urd_pkg::SER_IDLE : urd_pkg::SER_DATA;
          end
        end
        urd_pkg::SER_DATA: begin
          if (rx_mid) begin
            rx_shift_reg <= {rx_in, rx_shift_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 1'b1;
            if (rx_bit_reg == urd_pkg::DATA_LAST) begin
              rx_state_reg <= (ctl_reg.parity_on || aux_reg.mp_on) ? urd_pkg::SER_NINTH
                              : urd_pkg::SER_STOP;
            end
          end
        end
        urd_pkg::SER_NINTH: begin
          if (rx_mid) begin
            rx_ninth_reg <= rx_in;
            rx_state_reg <= urd_pkg::SER_STOP;
          end
        end
        urd_pkg::SER_STOP: begin
          if (rx_mid) begin
            rx_state_reg <= urd_pkg::SER_IDLE;
          end
        end
        default: rx_state_reg <= urd_pkg::SER_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Receive holding and status flags
  // ---------------------------------------------------------------
  // A new character wins over a read clear in the same cycle.
  logic rx_bad_parity;
  logic rx_break;
  logic rx_store;

  assign rx_bad_parity = ctl_reg.parity_on && !aux_reg.mp_on
                         && (((^rx_shift_reg) ^ ctl_reg.parity_odd) != rx_ninth_reg);
  assign rx_break = (rx_shift_reg == urd_pkg::BYTE_ZERO) && !rx_ninth_reg && !rx_stop_ok;
  assign rx_store = rx_done && !(rda_reg && !rd_hold);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rx_holding_reg <= urd_pkg::BYTE_ZERO;
      rda_reg <= 1'b0;
      pe_reg <= 1'b0;
      oe_reg <= 1'b0;
      fe_reg <= 1'b0;
      brk_reg <= 1'b0;
      first_reg <= 1'b0;
      ninth_reg <= 1'b0;
      prev_addr_reg <= 1'b0;
    end else if (i_ce) begin
      if (rx_store) begin
        rx_holding_reg <= rx_shift_reg;
      end
      if (rx_done) begin
        rda_reg <= 1'b1;
        pe_reg <= pe_reg | rx_bad_parity;
        fe_reg <= !rx_stop_ok || (fe_reg && !rd_hold);
        brk_reg <= rx_break || (brk_reg && !rd_hold);
        oe_reg <= (rda_reg && !rd_hold) || (oe_reg && !(rd_hold && !rda_reg));
        ninth_reg <= aux_reg.mp_on && rx_ninth_reg;
        first_reg <= (aux_reg.mp_on && prev_addr_reg && !rx_ninth_reg)
                     || (first_reg && !rd_hold);
        prev_addr_reg <= aux_reg.mp_on && rx_ninth_reg;
        if (rd_hold) begin
          pe_reg <= rx_bad_parity;
        end
      end else if (rd_hold) begin
        rda_reg <= 1'b0;
        pe_reg <= 1'b0;
        fe_reg <= 1'b0;
        brk_reg <= 1'b0;
        first_reg <= 1'b0;
        ninth_reg <= 1'b0;
        if (!rda_reg) begin
          oe_reg <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  urd_pkg::urd_line_status_s line_status;

  always_comb begin
    line_status.rx_byte_waiting = rda_reg;
    line_status.parity_fault = pe_reg;
    line_status.overrun = oe_reg;
    line_status.framing_fault = fe_reg;
    line_status.line_break_seen = brk_reg;
    line_status.tx_holding_empty = tx_holding_empty_reg;
    line_status.shifter_idle = (tx_state_reg == urd_pkg::SER_IDLE) && !fifo_out_valid;
    line_status.cts_level = cts_n_level_reg;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rdata <= urd_pkg::BYTE_ZERO;
      o_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        case (i_addr)
          urd_pkg::ADDR_HOLDING: o_rdata <= rx_holding_reg;
          urd_pkg::ADDR_LINE_STATUS: o_rdata <= line_status;
          urd_pkg::ADDR_LINE_CONTROL: o_rdata <= ctl_reg;
          urd_pkg::ADDR_AUX_CONTROL: o_rdata <= aux_reg;
          urd_pkg::ADDR_FRAME_STATUS: o_rdata <= {6'h00, first_reg, ninth_reg};
          urd_pkg::ADDR_DIV_HIGH: o_rdata <= aux_reg.divider_timer_ctl ? cnt_reg[15:8]
                                            : div_hi_reg;
          urd_pkg::ADDR_DIV_LOW: o_rdata <= aux_reg.divider_timer_ctl ? cnt_reg[7:0]
                                           : div_lo_reg;
          default: o_rdata <= urd_pkg::BYTE_ZERO;
        endcase
      end
    end
  end
endmodule : urd_top

/* File: sim/urd_top_properties.sv */
// Purpose: Port-level checks of the rate divider and status block
// Assumes: One clock domain, i_srst synchronous and active high
// Notes:   Timer spacing is judged only between pulses with no write between
`timescale 1ns/100ps
module urd_top_properties (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [11:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_serial_in_pin,
  input wire logic i_cts_n,
  input wire logic o_serial_out_pin,
  input wire logic o_timer_irq,
  input wire logic o_tx_ready
);
  // ----
  // Divisor shadow and pulse spacing
  // ----
  logic [15:0] div_reg;
  logic [15:0] gap_reg;
  logic seen_reg;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  always_ff @(posedge i_mclk) begin
    if (i_srst) div_reg <= 16'hffff;
    else if (i_ce && i_wr && i_addr == urd_pkg::ADDR_DIV_HIGH) div_reg[15:8] <= i_wdata;
    else if (i_ce && i_wr && i_addr == urd_pkg::ADDR_DIV_LOW) div_reg[7:0] <= i_wdata;
  end
  always_ff @(posedge i_mclk) begin
    if (i_srst || o_timer_irq) gap_reg <= 16'h0001;
    else if (i_ce) gap_reg <= gap_reg + 16'h0001;
  end
  // A divisor write reloads the counter and other writes may gate the pulse, so the next spacing is not judged
  always_ff @(posedge i_mclk) begin
    if (i_srst || (i_ce && i_wr)) seen_reg <= 1'b0;
    else if (o_timer_irq) seen_reg <= 1'b1;
  end
  chk_rd_answer: assert property (i_rd && i_ce |=> o_rvalid)
    else $error("read without answer");
  chk_rvalid_cause: assert property (o_rvalid |-> $past(i_rd))
    else $error("answer without read");
  chk_ctl_readback: assert property ((i_ce && i_wr && i_addr == urd_pkg::ADDR_LINE_CONTROL)
    ##2 (i_ce && i_rd && i_addr == urd_pkg::ADDR_LINE_CONTROL) |=> o_rdata == $past(i_wdata, 3))
    else $error("line control readback wrong");
  chk_frame_reserved: assert property (o_rvalid && $past(i_addr) == 12'hf44
    |-> o_rdata[7:2] == 6'h00) else $error("frame status reserved bits set");
  chk_cts_level: assert property ($stable(i_cts_n) [*6] ##0 (i_rd && i_ce
    && i_addr == urd_pkg::ADDR_LINE_STATUS) |=> o_rdata[0] == $past(i_cts_n))
    else $error("cts level wrong");
  chk_wait_clear: assert property ((i_rd && i_ce && i_addr == urd_pkg::ADDR_HOLDING) ##3
    (i_rd && i_ce && i_addr == urd_pkg::ADDR_LINE_STATUS) |=> !o_rdata[7])
    else $error("waiting flag not cleared");
  chk_tx_ready_drop: assert property (i_ce && i_wr && i_addr == urd_pkg::ADDR_HOLDING
    |=> !o_tx_ready) else $error("holding empty after write");
  chk_reset_idle: assert property ($fell(i_srst) |-> o_tx_ready && o_serial_out_pin
    && !o_timer_irq) else $error("reset state wrong");
  chk_timer_period: assert property (o_timer_irq && seen_reg && div_reg > 16'h0001
    |-> gap_reg == div_reg) else $error("timer spacing wrong");
  cover property (o_timer_irq && seen_reg);
  cover property (o_rvalid && $past(i_addr) == urd_pkg::ADDR_HOLDING);
  cover property ($fell(o_serial_out_pin));
endmodule : urd_top_properties

/* File: sim/urd_peer.sv */
// Purpose: Behavioural far-end serial transceiver
// Assumes: Line idles high; one bit lasts bit_cyc clocks
// Notes:   Sent frames always carry a ninth bit; received frames are sampled without one
`timescale 1ns/100ps
module urd_peer (
  input wire logic i_mclk,
  input wire logic i_serial_out_pin,
  output logic o_serial_in_pin
);
  // ----
  // Frame send and receive
  // ----
  int unsigned bit_cyc = 16;
  initial o_serial_in_pin = 1'b1;
  task automatic send(input logic [7:0] d, input logic b9, input logic stp);
    logic [10:0] f;
    f = {stp, b9, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge i_mclk);
      o_serial_in_pin <= f[i];
      repeat (bit_cyc - 1) @(posedge i_mclk);
    end
    @(posedge i_mclk);
    o_serial_in_pin <= 1'b1;
    repeat (bit_cyc * 2) @(posedge i_mclk);
  endtask : send
  // Samples mid-bit, LSB first, then checks the stop level
  task automatic recv(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    for (int n = 0; n < 4000 && !ok; n++) begin
      @(posedge i_mclk);
      ok = !i_serial_out_pin;
    end
    repeat (bit_cyc / 2) @(posedge i_mclk);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_cyc) @(posedge i_mclk);
      if (i < 8) d[i] = i_serial_out_pin;
      else ok = ok && i_serial_out_pin;
    end
  endtask : recv
endmodule : urd_peer

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the rate divider and status block
// Assumes: Register strobes are single-cycle pulses driven at the rising edge
// Notes:   Divisor 1 gives sixteen clocks per serial bit
`timescale 1ns/100ps
module testbench;
  // ----
  // Harness
  // ----
  localparam logic [11:0] HOLD = urd_pkg::ADDR_HOLDING;
  localparam logic [11:0] LS = urd_pkg::ADDR_LINE_STATUS;
  localparam logic [11:0] LC = urd_pkg::ADDR_LINE_CONTROL;
  localparam logic [11:0] AUX = urd_pkg::ADDR_AUX_CONTROL;
  localparam logic [11:0] FS = urd_pkg::ADDR_FRAME_STATUS;
  logic i_mclk = 1'b0, i_srst = 1'b1, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_cts_n = 1'b1;
  logic [11:0] i_addr = 12'h000;
  logic [7:0] i_wdata = 8'h00, o_rdata, rd_data, d;
  logic o_rvalid, o_serial_out_pin, o_timer_irq, o_tx_ready, serial_in, ok;
  int fails = 0, checks = 0;
  always #20 i_mclk = ~i_mclk;
  urd_top dut (.i_mclk, .i_srst, .i_ce, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_rvalid,
    .i_serial_in_pin(serial_in), .i_cts_n, .o_serial_out_pin, .o_timer_irq, .o_tx_ready);
  urd_peer peer (.i_mclk, .i_serial_out_pin(o_serial_out_pin), .o_serial_in_pin(serial_in));
  task automatic print_verdict;
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    for (n = 0; n < 4; n++) begin
      @(posedge i_mclk);
      if (o_rvalid === 1'b1) break;
    end
    if (n == 4) begin
      fails++;
      print_verdict;
    end
    rd_data = o_rdata;
  endtask : rd
  task automatic rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(rd_data & m, e);
  endtask : rdc
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rdc(LC, 8'hff, 8'h00);
    rdc(LS, 8'hfe, 8'h06);
    rdc(FS, 8'hff, 8'h00);
    i_cts_n <= 1'b0;
    repeat (5) @(posedge i_mclk);
    rdc(LS, 8'h01, 8'h00);
    i_cts_n <= 1'b1;
    repeat (5) @(posedge i_mclk);
    rdc(LS, 8'h01, 8'h01);
    wr(LC, 8'h3d);
    rdc(LC, 8'hff, 8'h3d);
    wr(LC, 8'h00);
  endtask : t_reset
  task automatic t_timer;
    int n, gap;
    wr(urd_pkg::ADDR_DIV_HIGH, 8'h00);
    wr(urd_pkg::ADDR_DIV_LOW, 8'h05);
    wr(AUX, 8'h04);
    for (n = 0; n < 50; n++) begin
      @(posedge i_mclk);
      if (o_timer_irq === 1'b1) break;
    end
    for (gap = 1; gap < 50; gap++) begin
      @(posedge i_mclk);
      if (o_timer_irq === 1'b1) break;
    end
    chk(8'(gap), 8'h05);
    wr(AUX, 8'h00);
    for (n = 0; n < 20 && o_timer_irq !== 1'b1; n++) @(posedge i_mclk);
    chk(8'(n), 8'h14);
    wr(urd_pkg::ADDR_DIV_LOW, 8'h01);
  endtask : t_timer
  task automatic t_tx;
    wr(LC, 8'h80);
    wr(HOLD, 8'h5a);
    wr(HOLD, 8'hc3);
    peer.recv(d, ok);
    chk({d[6:0], ok}, 8'hb5);
    peer.recv(d, ok);
    chk({d[6:0], ok}, 8'h87);
    rdc(LS, 8'h02, 8'h00);
    repeat (40) @(posedge i_mclk);
    rdc(LS, 8'h06, 8'h06);
    wr(LC, 8'h00);
  endtask : t_tx
  task automatic t_rx;
    logic [7:0] ed [2] = '{8'h01, 8'h00};
    logic es [2] = '{1'b1, 1'b0};
    logic [7:0] ex [2] = '{8'h40, 8'h18};
    wr(LC, 8'h50);
    peer.send(8'h3c, 1'b0, 1'b1);
    rdc(LS, 8'hf8, 8'h80);
    rdc(HOLD, 8'hff, 8'h3c);
    rdc(LS, 8'h80, 8'h00);
    peer.send(8'h11, 1'b0, 1'b1);
    peer.send(8'h22, 1'b0, 1'b1);
    rdc(HOLD, 8'hff, 8'h11);
    rd(FS);
    rdc(LS, 8'h20, 8'h20);
    rd(HOLD);
    rd(FS);
    rdc(LS, 8'h20, 8'h00);
    wr(AUX, 8'h40);
    peer.send(8'h55, 1'b1, 1'b1);
    rdc(FS, 8'h01, 8'h01);
    rd(HOLD);
    rdc(FS, 8'h01, 8'h00);
    peer.send(8'h66, 1'b0, 1'b1);
    rdc(FS, 8'h03, 8'h02);
    wr(AUX, 8'h00);
    for (int i = 0; i < 2; i++) begin
      peer.send(ed[i], 1'b0, es[i]);
      rdc(LS, 8'h58, ex[i]);
      rd(HOLD);
      rdc(LS, 8'h58, 8'h00);
    end
  endtask : t_rx
  initial begin
    repeat (8) @(posedge i_mclk);
    i_srst <= 1'b0;
    t_reset;
    t_timer;
    t_tx;
    t_rx;
    print_verdict;
  end
  initial begin
    repeat (60000) @(posedge i_mclk);
    fails++;
    print_verdict;
  end
endmodule : testbench
bind urd_top urd_top_properties chk (.i_mclk, .i_srst, .i_ce, .i_addr, .i_wr, .i_rd, .i_wdata,
  .o_rdata, .o_rvalid, .i_serial_in_pin, .i_cts_n, .o_serial_out_pin, .o_timer_irq, .o_tx_ready);
